// ---- tb/pll_holdover_status_regs_test.sv ----
// Self-checking bench for the PLL holdover status register bank
`timescale 1ns/1ps
`include "pllhs_regs.svh"
module pll_holdover_status_regs_test;
    import pllhs_pkg::*;

    logic        clk_sys_in;
    logic        sys_rst_in;
    logic        ce_in;
    pllhs_req_t  req_in;
    pllhs_stat_t stat_raw_in;
    logic [7:0]  rd_data_out;
    logic        rd_valid_out;
    logic        holdover_en_out;
    logic        ext_holdover_en_out;
    logic        ld_cmp_en_out;
    logic        doubler_en_out;
    logic        zero_delay_en_out;
    logic        thresh_sel_out;
    int          err_count;
    int          num_checks;
    pllhs_stat_t s;
    logic [7:0]  hd;

    pllhs_regs_top dut_u (
        .clk_sys_in          (clk_sys_in),
        .sys_rst_in          (sys_rst_in),
        .ce_in               (ce_in),
        .req_in              (req_in),
        .stat_raw_in         (stat_raw_in),
        .rd_data_out         (rd_data_out),
        .rd_valid_out        (rd_valid_out),
        .holdover_en_out     (holdover_en_out),
        .ext_holdover_en_out (ext_holdover_en_out),
        .ld_cmp_en_out       (ld_cmp_en_out),
        .doubler_en_out      (doubler_en_out),
        .zero_delay_en_out   (zero_delay_en_out),
        .thresh_sel_out      (thresh_sel_out)
    );

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    initial begin
        #20000;
        err_count++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_ctl(input logic [7:0] th, input logic [7:0] hr,
                                           input logic [7:0] zd);
        return {2'b00, th[6], hr[5], hr[3], zd[1], hr[1], hr[0]};
    endfunction

    function automatic logic [7:0] ctl_seen();
        return {2'b00, thresh_sel_out, doubler_en_out, ld_cmp_en_out, zero_delay_en_out,
                ext_holdover_en_out, holdover_en_out};
    endfunction

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        req_in.wr_en = 1'b1;
        req_in.addr  = a;
        req_in.wdata = d;
        @(negedge clk_sys_in);
        req_in.wr_en = 1'b0;
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
        @(negedge clk_sys_in);
        req_in.rd_en = 1'b1;
        req_in.addr  = a;
        @(negedge clk_sys_in);
        req_in.rd_en = 1'b0;
        chk({7'h00, rd_valid_out}, 8'h01);
        chk(rd_data_out, exp);
        @(negedge clk_sys_in);
        chk({7'h00, rd_valid_out}, 8'h00);
    endtask

    task automatic settle();
        repeat (4) @(negedge clk_sys_in);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        err_count   = 0;
        num_checks  = 0;
        sys_rst_in  = 1'b1;
        ce_in       = 1'b1;
        req_in      = '0;
        stat_raw_in = '0;
        void'($urandom(12));
        repeat (20) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        chk(ctl_seen(), 8'h00);
        rdchk(`PLLHS_ADDR_HOLD_CTRL, 8'h00);
        rdchk(`PLLHS_ADDR_ZD_CTRL, 8'h00);
        rdchk(`PLLHS_ADDR_STATUS, 8'h00);
        rdchk(10'h3ff, 8'h00);
        wr(`PLLHS_ADDR_HOLD_CTRL, 8'h01);
        chk(ctl_seen(), exp_ctl(8'h00, 8'h01, 8'h00));
        wr(`PLLHS_ADDR_ZD_CTRL, 8'hff);
        rdchk(`PLLHS_ADDR_ZD_CTRL, 8'h02);
        wr(`PLLHS_ADDR_THRESH_CTRL, 8'hff);
        rdchk(`PLLHS_ADDR_THRESH_CTRL, 8'h40);
        chk(ctl_seen(), exp_ctl(8'h40, 8'h01, 8'h02));
        wr(`PLLHS_ADDR_ZD_CTRL, 8'h00);
        chk(ctl_seen(), exp_ctl(8'h40, 8'h01, 8'h00));
        // Random conditions, holdover enable toggled apart from them
        for (int i = 0; i < 24; i++) begin
            s  = pllhs_stat_t'(6'($urandom()));
            hd = 8'($urandom()) & 8'h2b;
            wr(`PLLHS_ADDR_HOLD_CTRL, hd);
            chk(ctl_seen(), exp_ctl(8'h40, hd, 8'h00));
            stat_raw_in = s;
            settle();
            rdchk(`PLLHS_ADDR_STATUS, {2'b00, s});
            wr(`PLLHS_ADDR_STATUS, 8'($urandom()));
            chk(ctl_seen(), exp_ctl(8'h40, hd, 8'h00));
            rdchk(`PLLHS_ADDR_STATUS, {2'b00, s});
            rdchk(`PLLHS_ADDR_HOLD_CTRL, hd);
        end
        // Frozen readback while disabled
        s = 6'h2a;
        stat_raw_in = s;
        settle();
        wr(`PLLHS_ADDR_HOLD_CTRL, 8'h10);
        stat_raw_in = ~s;
        settle();
        rdchk(`PLLHS_ADDR_STATUS, {2'b00, s});
        wr(`PLLHS_ADDR_HOLD_CTRL, 8'h00);
        settle();
        rdchk(`PLLHS_ADDR_STATUS, {2'b00, ~s});
        // Masked bits stay clear
        wr(`PLLHS_ADDR_HOLD_CTRL, 8'hc4);
        rdchk(`PLLHS_ADDR_HOLD_CTRL, 8'h00);
        // Clock enable low drops the write
        wr(`PLLHS_ADDR_ZD_CTRL, 8'h02);
        chk({7'h00, zero_delay_en_out}, 8'h01);
        @(negedge clk_sys_in);
        ce_in = 1'b0;
        wr(`PLLHS_ADDR_ZD_CTRL, 8'h00);
        ce_in = 1'b1;
        @(negedge clk_sys_in);
        chk({7'h00, zero_delay_en_out}, 8'h01);
        // Reset in mid-run restores the defaults
        wr(`PLLHS_ADDR_HOLD_CTRL, 8'h01);
        chk(ctl_seen(), exp_ctl(8'h40, 8'h01, 8'h02));
        sys_rst_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        chk(ctl_seen(), 8'h00);
        rdchk(`PLLHS_ADDR_HOLD_CTRL, 8'h00);
        wrap_up();
    end

endmodule

// ---- verilog/pllhs_pkg.sv ----
// Types shared by the PLL holdover status register bank
package pllhs_pkg;

    // ----------------------------------------------------------------
    // Register access request from the serial control port
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [9:0] addr;
        logic [7:0] wdata;
    } pllhs_req_t;

    // ----------------------------------------------------------------
    // Monitored conditions, in status bit order 5 down to 0
    // ----------------------------------------------------------------
    typedef struct packed {
        logic holdover_active;
        logic secondary_ref_sel;
        logic clk_above_thresh;
        logic secondary_above_thresh;
        logic primary_above_thresh;
        logic pll_locked;
    } pllhs_stat_t;

    typedef struct packed {
        pllhs_stat_t stage1;
        pllhs_stat_t stage2;
    } pllhs_sync_state_t;

    typedef struct packed {
        logic [7:0] thresh_q;
        logic [7:0] hold_q;
        logic [7:0] zd_q;
        logic [7:0] status_q;
        logic [7:0] rd_data_q;
        logic       rd_valid_q;
    } pllhs_state_t;

endpackage

// ---- verilog/pllhs_regs.svh ----
// Register offsets, field positions, masks and reset values of the PLL status bank
`ifndef PLLHS_REGS_SVH
`define PLLHS_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define PLLHS_ADDR_W            10
`define PLLHS_ADDR_THRESH_CTRL  10'h01a
`define PLLHS_ADDR_HOLD_CTRL    10'h01d
`define PLLHS_ADDR_ZD_CTRL      10'h01e
`define PLLHS_ADDR_STATUS       10'h01f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PLLHS_THRESH_SEL_BIT    6
`define PLLHS_DOUBLER_EN_BIT    5
`define PLLHS_RB_DIS_BIT        4
`define PLLHS_LD_CMP_EN_BIT     3
`define PLLHS_EXT_HOLD_EN_BIT   1
`define PLLHS_HOLD_EN_BIT       0
`define PLLHS_ZD_EN_BIT         1

// ----------------------------------------------------------------
// Writable masks, status readback mask and reset values
// ----------------------------------------------------------------
`define PLLHS_THRESH_MASK       8'h40
`define PLLHS_HOLD_MASK         8'h3b
`define PLLHS_ZD_MASK           8'h02
`define PLLHS_STATUS_MASK       8'h3f
`define PLLHS_THRESH_RST        8'h00
`define PLLHS_HOLD_RST          8'h00
`define PLLHS_ZD_RST            8'h00
`define PLLHS_STATUS_RST        8'h00

`endif

// ---- verilog/pllhs_regs_top.sv ----
// PLL holdover, zero delay and status readback register bank
// Notes on behaviour
// - Writing one to the holdover enable bit turns the internal holdover function on.
// - The holdover enable bit is cleared by reset so holdover starts disabled.
// - Bit 1 of the zero delay control register enables zero delay and resets to zero.
// - Status bit 5 reads one only while the part is really in holdover, apart from the enable.
// - Status bit 4 reads zero for the primary or differential reference and one for secondary.
// - Status bit 3 reads one when the external clock frequency is above the monitor threshold.
// - Status bit 2 reads one when the secondary reference is above the selected threshold.
// - Status bit 1 reads one when the primary reference is above the selected threshold.
// - Status bit 0 shows digital lock detect, one when locked.
// - While the readback disable bit is set the status register holds its last contents.
`timescale 1ns/1ps
`include "pllhs_regs.svh"
module pllhs_regs_top (
    input  wire logic                   clk_sys_in,
    input  wire logic                   sys_rst_in,
    input  wire logic                   ce_in,
    input  wire pllhs_pkg::pllhs_req_t  req_in,
    input  wire pllhs_pkg::pllhs_stat_t stat_raw_in,
    output logic [7:0]                  rd_data_out,
    output logic                        rd_valid_out,
    output logic                        holdover_en_out,
    output logic                        ext_holdover_en_out,
    output logic                        ld_cmp_en_out,
    output logic                        doubler_en_out,
    output logic                        zero_delay_en_out,
    output logic                        thresh_sel_out
);
    import pllhs_pkg::*;

    pllhs_state_t st_q;
    pllhs_state_t st_d;
    pllhs_stat_t  stat_sync;
    logic         rb_dis;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------------------------------
    // Condition synchroniser
    // ----------------------------------------------------------------
    pllhs_status_sync u_sync (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .raw_in     (stat_raw_in),
        .sync_out   (stat_sync)
    );

    assign rb_dis = st_q.hold_q[`PLLHS_RB_DIS_BIT];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (ce_in) begin
            st_d.rd_valid_q = 1'b0;
            if (req_in.wr_en && hit(req_in.addr, `PLLHS_ADDR_HOLD_CTRL)) begin
                st_d.hold_q = req_in.wdata & `PLLHS_HOLD_MASK;
            end
            if (req_in.wr_en && hit(req_in.addr, `PLLHS_ADDR_ZD_CTRL)) begin
                st_d.zd_q = req_in.wdata & `PLLHS_ZD_MASK;
            end
            if (req_in.wr_en && hit(req_in.addr, `PLLHS_ADDR_THRESH_CTRL)) begin
                st_d.thresh_q = req_in.wdata & `PLLHS_THRESH_MASK;
            end
            if (!rb_dis) begin
                st_d.status_q = {2'b00, stat_sync};
            end
            if (req_in.rd_en) begin
                st_d.rd_valid_q = 1'b1;
                if (hit(req_in.addr, `PLLHS_ADDR_STATUS)) begin
                    st_d.rd_data_q = st_q.status_q & `PLLHS_STATUS_MASK;
                end else if (hit(req_in.addr, `PLLHS_ADDR_HOLD_CTRL)) begin
                    st_d.rd_data_q = st_q.hold_q;
                end else if (hit(req_in.addr, `PLLHS_ADDR_ZD_CTRL)) begin
                    st_d.rd_data_q = st_q.zd_q;
                end else if (hit(req_in.addr, `PLLHS_ADDR_THRESH_CTRL)) begin
                    st_d.rd_data_q = st_q.thresh_q;
                end else begin
                    st_d.rd_data_q = 8'h00;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            st_q.thresh_q   <= `PLLHS_THRESH_RST;
            st_q.hold_q     <= `PLLHS_HOLD_RST;
            st_q.zd_q       <= `PLLHS_ZD_RST;
            st_q.status_q   <= `PLLHS_STATUS_RST;
            st_q.rd_data_q  <= 8'h00;
            st_q.rd_valid_q <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rd_data_out         = st_q.rd_data_q;
    assign rd_valid_out        = st_q.rd_valid_q;
    assign holdover_en_out     = st_q.hold_q[`PLLHS_HOLD_EN_BIT];
    assign ext_holdover_en_out = st_q.hold_q[`PLLHS_EXT_HOLD_EN_BIT];
    assign ld_cmp_en_out       = st_q.hold_q[`PLLHS_LD_CMP_EN_BIT];
    assign doubler_en_out      = st_q.hold_q[`PLLHS_DOUBLER_EN_BIT];
    assign zero_delay_en_out   = st_q.zd_q[`PLLHS_ZD_EN_BIT];
    assign thresh_sel_out      = st_q.thresh_q[`PLLHS_THRESH_SEL_BIT];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_hold_en_write: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && req_in.wr_en && req_in.addr == `PLLHS_ADDR_HOLD_CTRL)
        |=> (holdover_en_out == $past(req_in.wdata[0])))
        else $error("holdover enable did not follow write");

    a_reset_defaults: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        $fell(sys_rst_in) |-> (!holdover_en_out && !zero_delay_en_out && !rd_valid_out))
        else $error("control bits not cleared after reset");

    a_zd_write: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && req_in.wr_en && req_in.addr == `PLLHS_ADDR_ZD_CTRL)
        |=> (zero_delay_en_out == $past(req_in.wdata[1])))
        else $error("zero delay enable did not follow write");

    a_hold_read: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && req_in.rd_en && req_in.addr == `PLLHS_ADDR_STATUS)
        |=> (rd_valid_out && rd_data_out[5] == $past(st_q.status_q[5])))
        else $error("holdover active readback wrong");

    a_stat_track: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && !rb_dis) ##1 (ce_in && !rb_dis) ##1 (ce_in && !rb_dis)
        |=> (st_q.status_q[5:0] == $past(stat_raw_in, 3)))
        else $error("status does not follow monitored conditions");

    a_stat_frozen: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (rb_dis && !(ce_in && req_in.wr_en && req_in.addr == `PLLHS_ADDR_HOLD_CTRL))
        |=> $stable(st_q.status_q))
        else $error("status changed while readback disabled");

    a_unused_zero: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && req_in.rd_en && req_in.addr == `PLLHS_ADDR_STATUS)
        |=> (rd_data_out[7:6] == 2'b00))
        else $error("unused status bits not zero");

    a_unmapped_read: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && req_in.rd_en && req_in.addr != `PLLHS_ADDR_STATUS
         && req_in.addr != `PLLHS_ADDR_HOLD_CTRL && req_in.addr != `PLLHS_ADDR_ZD_CTRL
         && req_in.addr != `PLLHS_ADDR_THRESH_CTRL)
        |=> (rd_valid_out && rd_data_out == 8'h00))
        else $error("unmapped read not zero");

    a_freeze_ce: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !ce_in |=> ($stable(st_q.hold_q) && $stable(rd_valid_out)))
        else $error("state moved with clock enable low");

    a_hold_keeps: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !(ce_in && req_in.wr_en && req_in.addr == `PLLHS_ADDR_HOLD_CTRL)
        |=> $stable(holdover_en_out))
        else $error("holdover enable moved without a write");

    a_zd_keeps: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !(ce_in && req_in.wr_en && req_in.addr == `PLLHS_ADDR_ZD_CTRL)
        |=> $stable(zero_delay_en_out))
        else $error("zero delay enable moved without a write");

    a_thresh_write: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && req_in.wr_en && req_in.addr == `PLLHS_ADDR_THRESH_CTRL)
        |=> (thresh_sel_out == $past(req_in.wdata[6])))
        else $error("threshold select did not follow write");

    a_thresh_keeps: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !(ce_in && req_in.wr_en && req_in.addr == `PLLHS_ADDR_THRESH_CTRL)
        |=> $stable(thresh_sel_out))
        else $error("threshold select moved without a write");

    a_status_wr_ignored: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && req_in.wr_en && req_in.addr == `PLLHS_ADDR_STATUS)
        |=> ($stable(st_q.hold_q) && $stable(st_q.zd_q) && $stable(st_q.thresh_q)))
        else $error("status write touched a control register");

    a_rd_pulse: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (ce_in && !req_in.rd_en) |=> !rd_valid_out)
        else $error("read valid without a read");

    a_rst_controls: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        $fell(sys_rst_in) |-> (!thresh_sel_out && !ext_holdover_en_out
                               && !doubler_en_out && !ld_cmp_en_out))
        else $error("other controls not cleared after reset");

endmodule

// ---- verilog/pllhs_status_sync.sv ----
// Two-stage synchroniser for the monitored PLL conditions
`timescale 1ns/1ps
module pllhs_status_sync
    import pllhs_pkg::*;
(
    input  wire logic               clk_sys_in,
    input  wire logic               sys_rst_in,
    input  wire logic               ce_in,
    input  wire pllhs_pkg::pllhs_stat_t raw_in,
    output pllhs_pkg::pllhs_stat_t  sync_out
);

    pllhs_sync_state_t st_q;
    pllhs_sync_state_t st_d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (ce_in) begin
            st_d.stage1 = raw_in;
            st_d.stage2 = st_q.stage1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Only the second stage leaves the module
    assign sync_out = st_q.stage2;

endmodule
